// File: common/ssf_pkg.sv
package ssf_pkg;

	// ------------------------------------------------------------------
	// Register map (byte addresses on the register bus).
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_STATUS  = 8'h00;
	localparam logic [7:0] ADDR_CONTROL = 8'h04;
	localparam logic [7:0] ADDR_TXDATA  = 8'h08;
	localparam logic [7:0] ADDR_RXDATA  = 8'h0c;

	// ------------------------------------------------------------------
	// Status field positions and reset value.
	// ------------------------------------------------------------------
	localparam int BIT_TX_EMPTY = 7;
	localparam int BIT_RX_FULL  = 6;
	localparam int BIT_OVERRUN  = 5;
	localparam int BIT_FRAMING  = 4;
	localparam int BIT_PARITY   = 3;
	localparam int BIT_TX_END   = 2;
	localparam int BIT_RX_MPB   = 1;
	localparam int BIT_TX_MPB   = 0;
	localparam logic [7:0] STATUS_RESET = 8'h84;

	// ------------------------------------------------------------------
	// Control field positions and reset value.
	// ------------------------------------------------------------------
	localparam int CTL_TX_IRQ_EN = 7;
	localparam int CTL_RX_IRQ_EN = 6;
	localparam int CTL_TX_EN     = 5;
	localparam int CTL_RX_EN     = 4;
	localparam int CTL_SYNC_MODE = 3;
	localparam int CTL_MULTIPROC = 2;
	localparam int CTL_PARITY_EN = 1;
	localparam int CTL_ODD       = 0;
	localparam logic [7:0] CONTROL_RESET = 8'h00;

	// Markers of the five read-then-clear flags, in status bit order 7..3.
	localparam int NUM_CLEARABLE = 5;
	localparam int CLEAR_LSB     = 3;

	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

endpackage

// File: logic/ssf_serial_status.sv
`timescale 1ns/10ps

// How it works
// - Status byte holds tx empty, rx full, overrun, framing, parity, tx end, mpb, tx_multiproc_bit.
// - Reset or standby loads status with only tx empty and tx end set.
// - Writing one to the five clearable flags does nothing; only zero clears.
// - A zero write clears a flag only after software read it as one.
// - Tx end and received mpb ignore software writes to their own bits.
// - Tx empty sets on holding-to-shift transfer and stays set while tx disabled.
// - Tx disable sets tx empty; a DMA write of tx holding clears it.
// - Rx full sets on error-free receive transfer; a DMA read clears it.
// - DMA read of rx holding clears rx full like software read-then-clear.
// - Overrun and rx disable leave rx holding contents unchanged; errors and rx disable leave rx full unchanged.
// - A character ending while rx full is set raises overrun and is dropped.
// - Any error flag stops reception; in clocked mode it stops transmission too.
// - Asynchronous framing flag sets when the stop bit samples as zero.
// - With two stop bits only the first stop bit is checked.
// - Framing error stores the character but leaves rx full clear.
// - Asynchronous parity flag sets when ones count mismatches even or odd setting.
// - Parity error stores the character but leaves rx full clear.
// - Rx disable leaves overrun, framing and parity flags unchanged.
// - Tx end sets on last bit with tx empty, on reset, and on tx disable.
// - Tx end clears whenever tx empty is cleared by software or DMA, except in a cycle where last bit sets it.
// - Multiprocessor format captures each received mpb; rx disable keeps it.
// - Tx mpb goes out only in asynchronous multiprocessor format while transmitting.
// - Tx empty interrupt requested while tx empty and its enable are set.
// - Rx interrupt enable gates rx full and error interrupts; error from three flags.
module ssf_serial_status (
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        RST_N,
	input  wire logic        STANDBY,
	// AHB-Lite slave
	input  wire logic        HSEL,
	input  wire logic [7:0]  HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	// DMA controller accesses to the data registers
	input  wire logic        DMA_TX_WRITE,
	input  wire logic [7:0]  DMA_TX_DATA,
	input  wire logic        DMA_RX_READ,
	// Transmit shifter side
	input  wire logic        TX_LOAD,
	input  wire logic        TX_LAST_BIT,
	output logic      [7:0]  TX_HOLDING,
	output logic             TX_MPB_OUT,
	output logic             TX_ALLOWED,
	// Receive shifter side
	input  wire logic        RX_DONE,
	input  wire logic [7:0]  RX_DATA,
	input  wire logic        RX_PARITY_BIT,
	input  wire logic        RX_STOP_BIT,
	input  wire logic        RX_MPB_IN,
	output logic             RX_ALLOWED,
	// Configuration and interrupt requests
	output logic             TX_ENABLE,
	output logic             RX_ENABLE,
	output logic             SYNC_MODE,
	output logic             TX_EMPTY_IRQ,
	output logic             RX_FULL_IRQ,
	output logic             RX_ERROR_IRQ
);

	// ------------------------------------------------------------------
	// Bus decode.
	// ------------------------------------------------------------------
	logic       ph_valid_reg;
	logic       ph_write_reg;
	logic [7:0] ph_addr_reg;
	logic       start;
	logic       wr_status;
	logic       wr_control;
	logic       wr_txdata;
	logic       rd_status;
	logic       rd_rxdata;
	logic       hit_status;
	logic       hit_control;
	logic       hit_txdata;
	logic       hit_rxdata;

	// HSIZE is not decoded: every register is one aligned word, and byte lanes
	// 31..8 read as zero.
	assign start = HSEL && HREADY && (HTRANS == ssf_pkg::HTRANS_NONSEQ);

	// The decode works on the address captured in the address phase, so every
	// action lands at the end of the data phase, where HWDATA is valid.
	assign hit_status  = ph_valid_reg && ph_addr_reg == ssf_pkg::ADDR_STATUS;
	assign hit_control = ph_valid_reg && ph_addr_reg == ssf_pkg::ADDR_CONTROL;
	assign hit_txdata  = ph_valid_reg && ph_addr_reg == ssf_pkg::ADDR_TXDATA;
	assign hit_rxdata  = ph_valid_reg && ph_addr_reg == ssf_pkg::ADDR_RXDATA;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ph_valid_reg <= 1'b0;
			ph_write_reg <= 1'b0;
			ph_addr_reg  <= 8'h00;
		end else begin
			ph_valid_reg <= start;
			ph_write_reg <= HWRITE;
			ph_addr_reg  <= HADDR;
		end
	end

	always_comb begin
		wr_status  = 1'b0;
		wr_control = 1'b0;
		wr_txdata  = 1'b0;
		rd_status  = 1'b0;
		rd_rxdata  = 1'b0;
		// The hits are one-hot because the addresses differ, so the order of this
		// chain does not matter.
		if (hit_status && ph_write_reg) begin
			wr_status = 1'b1;
		end else if (hit_control && ph_write_reg) begin
			wr_control = 1'b1;
		end else if (hit_txdata && ph_write_reg) begin
			wr_txdata = 1'b1;
		end else if (hit_status && !ph_write_reg) begin
			rd_status = 1'b1;
		end else if (hit_rxdata && !ph_write_reg) begin
			rd_rxdata = 1'b1;
		end
	end

	// No wait states: every register answers in the data phase, so the master never stalls.
	assign HREADYOUT = 1'b1;
	assign HRESP     = 1'b0;

	// ------------------------------------------------------------------
	// Control register.
	// ------------------------------------------------------------------
	logic [7:0] control_reg;

	// Standby returns the control bits to their reset state as reset does; the
	// holding registers are left alone so that data survives a short standby.
	always_ff @(posedge CLK) begin
		if (!RST_N || STANDBY) begin
			control_reg <= ssf_pkg::CONTROL_RESET;
		end else if (wr_control) begin
			control_reg <= HWDATA[7:0];
		end
	end

	assign TX_ENABLE = control_reg[ssf_pkg::CTL_TX_EN];
	assign RX_ENABLE = control_reg[ssf_pkg::CTL_RX_EN];
	assign SYNC_MODE = control_reg[ssf_pkg::CTL_SYNC_MODE];

	// ------------------------------------------------------------------
	// Receive character checks.
	// ------------------------------------------------------------------
	logic status_err;
	logic multiproc;
	logic framing_err;
	logic parity_err;
	logic rx_accept;
	logic rx_overrun;
	logic rx_clean;
	logic [7:0] status_reg;

	assign status_err = status_reg[ssf_pkg::BIT_OVERRUN] | status_reg[ssf_pkg::BIT_FRAMING]
		| status_reg[ssf_pkg::BIT_PARITY];
	assign multiproc  = control_reg[ssf_pkg::CTL_MULTIPROC] && !SYNC_MODE;
	// Only the first stop bit is presented here; a second one is never checked.
	assign framing_err = !SYNC_MODE && !RX_STOP_BIT;
	// Multiprocessor format carries no parity bit, so the check is skipped there.
	assign parity_err  = !SYNC_MODE && !multiproc && control_reg[ssf_pkg::CTL_PARITY_EN]
		&& ((^RX_DATA ^ RX_PARITY_BIT) != control_reg[ssf_pkg::CTL_ODD]);
	// A strobe that arrives while reception is halted is ignored altogether; the
	// peer must not expect it to be held over.
	assign rx_accept  = RX_DONE && RX_ALLOWED;
	// An overrun keeps the character out of rx holding, but its mpb is still captured
	// and its framing and parity checks still set their flags beside the overrun flag.
	assign rx_overrun = rx_accept && status_reg[ssf_pkg::BIT_RX_FULL];
	assign rx_clean   = rx_accept && !rx_overrun && !framing_err && !parity_err;

	// Errors halt reception until software clears them; in clocked mode both
	// directions share one clock, so transmission halts as well.
	assign RX_ALLOWED = RX_ENABLE && !status_err;
	assign TX_ALLOWED = TX_ENABLE && !(SYNC_MODE && status_err);

	// ------------------------------------------------------------------
	// Data holding registers.
	// ------------------------------------------------------------------
	logic [7:0] rx_holding_reg;
	logic [7:0] tx_holding_reg;
	logic [7:0] rx_holding_next;
	logic [7:0] tx_holding_next;

	// A character that overruns is lost; the one already waiting stays intact.
	always_comb begin
		rx_holding_next = rx_holding_reg;
		if (rx_accept && !rx_overrun) begin
			rx_holding_next = RX_DATA;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			rx_holding_reg <= 8'h00;
		end else begin
			rx_holding_reg <= rx_holding_next;
		end
	end

	// The DMA controller wins a collision with a software write, since its
	// transfer cannot be retried by the bus.
	always_comb begin
		tx_holding_next = tx_holding_reg;
		if (DMA_TX_WRITE) begin
			tx_holding_next = DMA_TX_DATA;
		end else if (wr_txdata) begin
			tx_holding_next = HWDATA[7:0];
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			tx_holding_reg <= 8'h00;
		end else begin
			tx_holding_reg <= tx_holding_next;
		end
	end

	assign TX_HOLDING = tx_holding_reg;
	assign TX_MPB_OUT = multiproc && TX_ALLOWED && status_reg[ssf_pkg::BIT_TX_MPB];

	// ------------------------------------------------------------------
	// Read-as-one markers for bits 7..3.
	// ------------------------------------------------------------------
	logic [ssf_pkg::NUM_CLEARABLE-1:0] seen_reg;
	logic [ssf_pkg::NUM_CLEARABLE-1:0] clr;
	logic [ssf_pkg::NUM_CLEARABLE-1:0] set;

	// A flag that sets in the same cycle as its clear stays set.
	// Index 4 of these vectors is status bit 7, index 0 is status bit 3.
	assign set[4] = !TX_ENABLE || TX_LOAD;
	assign set[3] = rx_clean;
	assign set[2] = rx_overrun;
	assign set[1] = rx_accept && framing_err;
	assign set[0] = rx_accept && parity_err;

	// A marker is dropped as soon as its flag reads zero, so a read made before
	// an earlier event can never arm the clear of a later one. Software must
	// therefore read again after every new event before it writes zero.
	genvar g;
	generate
		for (g = 0; g < ssf_pkg::NUM_CLEARABLE; g++) begin : g_clear
			assign clr[g] = wr_status && !HWDATA[ssf_pkg::CLEAR_LSB+g]
				&& seen_reg[g];
			always_ff @(posedge CLK) begin
				if (!RST_N || STANDBY) begin
					seen_reg[g] <= 1'b0;
				end else if (rd_status && status_reg[ssf_pkg::CLEAR_LSB+g]) begin
					seen_reg[g] <= 1'b1;
				end else if (clr[g] || !status_reg[ssf_pkg::CLEAR_LSB+g]) begin
					seen_reg[g] <= 1'b0;
				end
			end
			always_ff @(posedge CLK) begin
				if (!RST_N || STANDBY) begin
					status_reg[ssf_pkg::CLEAR_LSB+g] <= ssf_pkg::STATUS_RESET[ssf_pkg::CLEAR_LSB+g];
				end else if (set[g]) begin
					status_reg[ssf_pkg::CLEAR_LSB+g] <= 1'b1;
				end else if (clr[g] || (g == 4 && DMA_TX_WRITE) || (g == 3 && DMA_RX_READ)) begin
					status_reg[ssf_pkg::CLEAR_LSB+g] <= 1'b0;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// Hardware-only and plain bits.
	// ------------------------------------------------------------------
	logic tx_empty_clear;

	// Tx end follows tx empty down, but never in a cycle in which tx empty is
	// being set again, so tx end never clears while tx empty stays set.
	assign tx_empty_clear = !set[4] && (clr[4] || DMA_TX_WRITE);

	always_ff @(posedge CLK) begin
		if (!RST_N || STANDBY) begin
			status_reg[ssf_pkg::BIT_TX_END] <= 1'b1;
		end else if (!TX_ENABLE || (TX_LAST_BIT && status_reg[ssf_pkg::BIT_TX_EMPTY])) begin
			status_reg[ssf_pkg::BIT_TX_END] <= 1'b1;
		end else if (tx_empty_clear) begin
			status_reg[ssf_pkg::BIT_TX_END] <= 1'b0;
		end
	end

	// Outside multiprocessor format the captured bit is left alone rather than
	// cleared, so a switch of format does not lose it.
	always_ff @(posedge CLK) begin
		if (!RST_N || STANDBY) begin
			status_reg[ssf_pkg::BIT_RX_MPB] <= 1'b0;
		end else if (rx_accept && multiproc) begin
			status_reg[ssf_pkg::BIT_RX_MPB] <= RX_MPB_IN;
		end
	end

	// The bit to send is plain storage; it reaches the line only through TX_MPB_OUT.
	always_ff @(posedge CLK) begin
		if (!RST_N || STANDBY) begin
			status_reg[ssf_pkg::BIT_TX_MPB] <= 1'b0;
		end else if (wr_status) begin
			status_reg[ssf_pkg::BIT_TX_MPB] <= HWDATA[ssf_pkg::BIT_TX_MPB];
		end
	end

	// ------------------------------------------------------------------
	// Named views of the status and control bits.
	// ------------------------------------------------------------------
	// Naming each bit keeps the read path and the interrupt requests readable
	// and makes the status order 7..0 visible in one place.
	logic tx_holding_empty;
	logic rx_holding_full;
	logic overrun_flag;
	logic framing_flag;
	logic parity_flag;
	logic tx_end_flag;
	logic rx_multiproc_bit;
	logic tx_multiproc_bit;
	logic tx_irq_enable;
	logic rx_irq_enable;

	assign tx_holding_empty = status_reg[ssf_pkg::BIT_TX_EMPTY];
	assign rx_holding_full  = status_reg[ssf_pkg::BIT_RX_FULL];
	assign overrun_flag     = status_reg[ssf_pkg::BIT_OVERRUN];
	assign framing_flag     = status_reg[ssf_pkg::BIT_FRAMING];
	assign parity_flag      = status_reg[ssf_pkg::BIT_PARITY];
	assign tx_end_flag      = status_reg[ssf_pkg::BIT_TX_END];
	assign rx_multiproc_bit = status_reg[ssf_pkg::BIT_RX_MPB];
	assign tx_multiproc_bit = status_reg[ssf_pkg::BIT_TX_MPB];
	assign tx_irq_enable    = control_reg[ssf_pkg::CTL_TX_IRQ_EN];
	assign rx_irq_enable    = control_reg[ssf_pkg::CTL_RX_IRQ_EN];

	// ------------------------------------------------------------------
	// Read data and interrupt requests.
	// ------------------------------------------------------------------
	always_comb begin
		HRDATA = 32'h0000_0000;
		if (hit_status) begin
			HRDATA = {24'h00_0000, tx_holding_empty, rx_holding_full, overrun_flag,
				framing_flag, parity_flag, tx_end_flag, rx_multiproc_bit,
				tx_multiproc_bit};
		end else if (hit_control) begin
			HRDATA = {24'h00_0000, control_reg};
		end else if (hit_txdata) begin
			HRDATA = {24'h00_0000, tx_holding_reg};
		end else if (hit_rxdata) begin
			HRDATA = {24'h00_0000, rx_holding_reg};
		end
	end

	// Requests are levels: each falls as soon as its flag is cleared or its enable dropped.
	assign TX_EMPTY_IRQ = tx_holding_empty && tx_irq_enable;
	assign RX_FULL_IRQ  = rx_holding_full && rx_irq_enable;
	assign RX_ERROR_IRQ = (overrun_flag || framing_flag || parity_flag)
		&& rx_irq_enable;

endmodule

// File: bench/ssf_status_props.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Port checks of the status block.
// ------------------------------------------------------------
module ssf_status_props (
	// Clock and reset
	input wire logic        CLK,
	input wire logic        RST_N,
	input wire logic        STANDBY,
	// Register bus
	input wire logic        HSEL,
	input wire logic [7:0]  HADDR,
	input wire logic [1:0]  HTRANS,
	input wire logic        HWRITE,
	input wire logic        HREADY,
	input wire logic [31:0] HRDATA,
	// Strobes and shifter side
	input wire logic        DMA_TX_WRITE,
	input wire logic [7:0]  DMA_TX_DATA,
	input wire logic [7:0]  TX_HOLDING,
	input wire logic        TX_MPB_OUT,
	input wire logic        TX_ALLOWED,
	input wire logic        RX_DONE,
	input wire logic        RX_STOP_BIT,
	input wire logic        RX_ALLOWED,
	// Configuration
	input wire logic        TX_ENABLE,
	input wire logic        RX_ENABLE,
	input wire logic        SYNC_MODE,
	input wire logic        TX_EMPTY_IRQ
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	logic stat_rd;
	assign stat_rd = HSEL && HREADY && HTRANS == ssf_pkg::HTRANS_NONSEQ && !HWRITE
		&& HADDR == ssf_pkg::ADDR_STATUS;
	a_tx_gated: assert property (TX_ALLOWED |-> TX_ENABLE)
		else $error("transmit allowed while disabled");
	a_rx_gated: assert property (RX_ALLOWED |-> RX_ENABLE)
		else $error("receive allowed while disabled");
	a_mpb_gated: assert property (TX_MPB_OUT |-> TX_ALLOWED && !SYNC_MODE)
		else $error("multiprocessor bit sent outside async transmit");
	a_upper_zero: assert property (HRDATA[31:8] == 24'h0)
		else $error("read data wider than a byte");
	a_frame_stops: assert property (RX_DONE && RX_ALLOWED && !SYNC_MODE && !RX_STOP_BIT
		&& !STANDBY |=> !RX_ALLOWED) else $error("bad stop bit did not halt reception");
	a_dma_loads: assert property (DMA_TX_WRITE |=> TX_HOLDING == $past(DMA_TX_DATA))
		else $error("dma write not held");
	a_standby_init: assert property (STANDBY |=> !TX_ENABLE && !RX_ENABLE && !TX_EMPTY_IRQ)
		else $error("standby did not clear control");
	// Both cycles disabled, so a register-lagged hold of the empty flag is still accepted.
	a_disabled_empty: assert property ($past(stat_rd) && !TX_ENABLE && !$past(TX_ENABLE)
		|-> HRDATA[7]) else $error("empty flag low while transmit disabled");
endmodule

bind ssf_serial_status ssf_status_props u_props (.CLK, .RST_N, .STANDBY, .HSEL, .HADDR, .HTRANS,
	.HWRITE, .HREADY, .HRDATA, .DMA_TX_WRITE, .DMA_TX_DATA, .TX_HOLDING, .TX_MPB_OUT,
	.TX_ALLOWED, .RX_DONE, .RX_STOP_BIT, .RX_ALLOWED, .TX_ENABLE, .RX_ENABLE, .SYNC_MODE,
	.TX_EMPTY_IRQ);

// File: bench/ssf_peer.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Remote serial side: finished characters and shifter strobes.
// ------------------------------------------------------------
module ssf_peer (
	// Clock
	input wire logic CLK,
	// Strobes towards the block
	output logic       TX_LOAD,
	output logic       TX_LAST_BIT,
	output logic       RX_DONE,
	output logic [7:0] RX_DATA,
	output logic       RX_PARITY_BIT,
	output logic       RX_STOP_BIT,
	output logic       RX_MPB_IN
);
	initial begin
		{TX_LOAD, TX_LAST_BIT, RX_DONE} = 3'h0;
		{RX_DATA, RX_PARITY_BIT, RX_STOP_BIT, RX_MPB_IN} = 11'h2aa;
	end
	// Off the strobe the lines show the inverse, so late sampling cannot match by luck.
	task automatic rx_char(input logic [7:0] d, input logic p, input logic s, input logic m);
		RX_DONE <= 1'b1;
		RX_DATA <= d;
		RX_PARITY_BIT <= p;
		RX_STOP_BIT <= s;
		RX_MPB_IN <= m;
		@(posedge CLK);
		RX_DONE <= 1'b0;
		{RX_DATA, RX_PARITY_BIT, RX_STOP_BIT, RX_MPB_IN} <= ~{d, p, s, m};
		@(posedge CLK);
	endtask
	task automatic tx_step(input logic last);
		TX_LOAD <= !last;
		TX_LAST_BIT <= last;
		@(posedge CLK);
		TX_LOAD <= 1'b0;
		TX_LAST_BIT <= 1'b0;
		@(posedge CLK);
	endtask
endmodule

// File: bench/ssf_serial_status_tb_top.sv
`timescale 1ns/10ps
module ssf_serial_status_tb_top;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        standby = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic        dma_wr = 1'b0;
	logic        dma_rd = 1'b0;
	logic [1:0]  htrans = 2'b00;
	logic [7:0]  haddr = 8'h00;
	logic [7:0]  dma_data = 8'h00;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic [7:0]  tx_holding, rx_data;
	logic        hreadyout, hresp, tx_mpb, tx_ok, rx_ok, tx_en, rx_en, sync, tx_irq, rx_irq;
	logic        err_irq, tx_load, tx_last, rx_done, rx_par, rx_stop, rx_mpb;
	int          miscompares = 0;
	int          n_compared = 0;
	localparam logic [7:0] S = ssf_pkg::ADDR_STATUS;
	localparam logic [7:0] C = ssf_pkg::ADDR_CONTROL;
	localparam logic [7:0] R = ssf_pkg::ADDR_RXDATA;
	always #50 clk = ~clk;
	ssf_serial_status u_dut (.CLK(clk), .RST_N(rst_n), .STANDBY(standby), .HSEL(hsel),
		.HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata),
		.HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
		.DMA_TX_WRITE(dma_wr), .DMA_TX_DATA(dma_data), .DMA_RX_READ(dma_rd), .TX_LOAD(tx_load),
		.TX_LAST_BIT(tx_last), .TX_HOLDING(tx_holding), .TX_MPB_OUT(tx_mpb), .TX_ALLOWED(tx_ok),
		.RX_DONE(rx_done), .RX_DATA(rx_data), .RX_PARITY_BIT(rx_par), .RX_STOP_BIT(rx_stop),
		.RX_MPB_IN(rx_mpb), .RX_ALLOWED(rx_ok), .TX_ENABLE(tx_en), .RX_ENABLE(rx_en),
		.SYNC_MODE(sync), .TX_EMPTY_IRQ(tx_irq), .RX_FULL_IRQ(rx_irq), .RX_ERROR_IRQ(err_irq));
	ssf_peer u_peer (.CLK(clk), .TX_LOAD(tx_load), .TX_LAST_BIT(tx_last), .RX_DONE(rx_done),
		.RX_DATA(rx_data), .RX_PARITY_BIT(rx_par), .RX_STOP_BIT(rx_stop), .RX_MPB_IN(rx_mpb));
	// ------------------------------------------------------------
	// Bus and strobe helpers.
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t saw %h wanted %h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= ssf_pkg::HTRANS_NONSEQ;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		do @(posedge clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(q, {24'h0, e});
	endtask
	task automatic dma(input logic w, input logic [7:0] d);
		dma_wr <= w;
		dma_rd <= !w;
		dma_data <= d;
		@(posedge clk);
		dma_wr <= 1'b0;
		dma_rd <= 1'b0;
		dma_data <= ~d;
		@(posedge clk);
	endtask
	task automatic give_verdict;
		$display("compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// A whole run takes some 130 cycles; fifteen times that means a hang.
	initial begin
		#200000;
		miscompares++;
		give_verdict;
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		rd(S, 8'h84);
		rd(C, 8'h00);
		chk({30'h0, hresp, hreadyout}, 32'h1);
		rd(8'h10, 8'h00);
		wr(S, 8'hff);
		rd(S, 8'h85);
		wr(C, 8'h30);
		wr(S, 8'h00);
		rd(S, 8'h00);
		u_peer.tx_step(1'b0);
		rd(S, 8'h80);
		u_peer.tx_step(1'b1);
		rd(S, 8'h84);
		wr(S, 8'hfa);
		rd(S, 8'h84);
		dma(1'b1, 8'h5a);
		rd(S, 8'h00);
		chk({24'h0, tx_holding}, 32'h5a);
		wr(C, 8'h10);
		rd(S, 8'h84);
		$display("transmit flags test done");
		wr(C, 8'h34);
		u_peer.rx_char(8'h3c, 1'b0, 1'b1, 1'b1);
		wr(S, 8'hbe);
		rd(S, 8'hc6);
		wr(S, 8'hbe);
		rd(S, 8'h86);
		rd(R, 8'h3c);
		u_peer.rx_char(8'ha5, 1'b1, 1'b1, 1'b0);
		rd(S, 8'hc4);
		dma(1'b0, 8'h00);
		rd(S, 8'h84);
		u_peer.rx_char(8'h11, 1'b0, 1'b1, 1'b0);
		u_peer.rx_char(8'h22, 1'b0, 1'b1, 1'b0);
		chk({31'h0, rx_ok}, 32'h0);
		wr(C, 8'h20);
		rd(S, 8'he4);
		rd(R, 8'h11);
		wr(S, 8'h9e);
		rd(S, 8'h84);
		$display("receive flags test done");
		wr(C, 8'h30);
		u_peer.rx_char(8'h77, 1'b0, 1'b0, 1'b1);
		rd(S, 8'h94);
		u_peer.rx_char(8'h55, 1'b0, 1'b1, 1'b0);
		rd(R, 8'h77);
		wr(S, 8'hee);
		wr(C, 8'h72);
		u_peer.rx_char(8'h01, 1'b0, 1'b1, 1'b0);
		rd(S, 8'h8c);
		chk({31'h0, err_irq}, 32'h1);
		rd(R, 8'h01);
		wr(S, 8'hf6);
		wr(C, 8'h73);
		u_peer.rx_char(8'h01, 1'b0, 1'b1, 1'b0);
		rd(S, 8'hc4);
		chk({31'h0, rx_irq}, 32'h1);
		$display("receive error test done");
		wr(C, 8'ha4);
		wr(S, 8'hf9);
		rd(S, 8'hc5);
		chk({30'h0, tx_mpb, tx_irq}, 32'h3);
		wr(C, 8'hac);
		rd(C, 8'hac);
		chk({31'h0, tx_mpb}, 32'h0);
		chk({31'h0, tx_ok}, 32'h1);
		standby <= 1'b1;
		@(posedge clk);
		standby <= 1'b0;
		rd(S, 8'h84);
		rd(C, 8'h00);
		$display("multiprocessor and standby test done");
		give_verdict;
	end
endmodule
